/* txs_top.sv */
// Transmit output serializer top: AXI4-Lite register file plus the serializer core.
// Assumes a single 20 MHz clock, synchronous active-low reset, one access of each kind at a time.
//
// How it works
// - Drive level bits 7:3 set the enabled slice count.
// - Drive level bits 2:0 set the per-slice bias.
// - Nine-bit word selects tuning capacitance linearly.
// - Tuning word: high byte at lower address, bits 15:9 read zero.
// - Boost bit multiplies amplifier bias by 1.5.
// - Symbols leave at the programmed rate without gaps.
// - One-byte pipeline with handshake; software refills it in time.
// - FSK drives seven-bit deviation bus; OOK keys the amplifier.
// - Front-end power switched only when needed.
// - Amplifier edges ramp at a controlled rate.
// - On underrun: power down, repeat last group, send zeros or ones.
// - Force-deviation bit deviates oscillator whatever data or mode.
// - Three test bits force oscillator, divider or amplifier on.
// - Forced amplifier passes programmed slice count straight through.
// - Serializer runs only while control bit zero is one.
// - Data write clears empty flag and gives one registered pulse.
// - Serializer clock is system clock divided by field plus one.
// - Symbol rate is base clock over rate field times divide factor.
// - Groups hold two to eight symbols, sent least significant first.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module txs_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [17:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [17:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             lc_oscillator_on,
   output logic             divider_on,
   output logic             amplifier_on,
   output logic [4:0]       driver_slice_count,
   output logic [2:0]       slice_bias_level,
   output logic             max_drive_boost,
   output logic [8:0]       tuning_cap_word,
   output logic [6:0]       freq_deviation
);
   logic [7:0]  ctrl_q;
   logic [7:0]  timing_q;
   logic [7:0]  data_q;
   logic [14:0] rate_q;
   logic [7:0]  level_q;
   logic [8:0]  cap_q;
   logic [7:0]  trim_q;
   logic        empty_q;
   logic        notify_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic [15:0] aw_idx_q;
   logic [31:0] w_data_q;
   logic        w_strb0_q;
   logic        take;
   logic        busy;
   txs_pkg::txs_rf_s  rf;
   txs_pkg::txs_cfg_s cfg;

   // Write decode once address and data are both held
   wire        wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
   wire        wr_en   = wr_go && w_strb0_q;
   wire [7:0]  wb      = w_data_q[7:0];
   wire        wr_ctrl = wr_en && aw_idx_q == txs_pkg::IDX_CTRL;
   wire        wr_tim  = wr_en && aw_idx_q == txs_pkg::IDX_TIMING;
   wire        wr_data = wr_en && aw_idx_q == txs_pkg::IDX_DATA;
   wire        wr_rl   = wr_en && aw_idx_q == txs_pkg::IDX_RATEL;
   wire        wr_rh   = wr_en && aw_idx_q == txs_pkg::IDX_RATEH;
   wire        wr_lvl  = wr_en && aw_idx_q == txs_pkg::IDX_LEVEL;
   wire        wr_chi  = wr_en && aw_idx_q == txs_pkg::IDX_CAP_HI;
   wire        wr_clo  = wr_en && aw_idx_q == txs_pkg::IDX_CAP_LO;
   wire        wr_trim = wr_en && aw_idx_q == txs_pkg::IDX_TRIM;
   wire        aw_ok   = s_axi_awaddr[1:0] == 2'b00;
   wire        wr_map  = aw_idx_q inside {txs_pkg::IDX_CTRL, txs_pkg::IDX_TIMING,
                         txs_pkg::IDX_DATA, txs_pkg::IDX_RATEL, txs_pkg::IDX_RATEH,
                         txs_pkg::IDX_LEVEL, txs_pkg::IDX_CAP_HI, txs_pkg::IDX_CAP_LO,
                         txs_pkg::IDX_TRIM, txs_pkg::IDX_STATUS};

   // Read decode
   wire [15:0] ar_idx  = s_axi_araddr[17:2];
   wire        rd_go   = s_axi_arvalid && !s_axi_rvalid;
   logic [7:0] rd_byte;
   logic       rd_hit;
   always_comb begin
      rd_hit  = 1'b1;
      case (ar_idx)
         txs_pkg::IDX_CTRL:   rd_byte = ctrl_q;
         txs_pkg::IDX_TIMING: rd_byte = timing_q;
         txs_pkg::IDX_DATA:   rd_byte = data_q;
         txs_pkg::IDX_RATEL:  rd_byte = rate_q[7:0];
         txs_pkg::IDX_RATEH:  rd_byte = {1'b0, rate_q[14:8]};
         txs_pkg::IDX_LEVEL:  rd_byte = level_q;
         txs_pkg::IDX_CAP_HI: rd_byte = {7'h00, cap_q[8]}; // Bits 15:9 read zero
         txs_pkg::IDX_CAP_LO: rd_byte = cap_q[7:0];
         txs_pkg::IDX_TRIM:   rd_byte = trim_q;
         txs_pkg::IDX_STATUS: rd_byte = {6'h00, busy, empty_q};
         default: begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // AXI4-Lite handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid} <= '0;
         {s_axi_bresp, s_axi_rresp, s_axi_rdata, aw_have_q, w_have_q} <= '0;
         {aw_idx_q, w_data_q, w_strb0_q} <= '0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= aw_ok ? s_axi_awaddr[17:2] : 16'hFFFF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q  <= 1'b1;
            w_data_q  <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= rd_go && !s_axi_arready;
         if (rd_go && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= (rd_hit && s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register file
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q   <= txs_pkg::CTRL_RST;
         timing_q <= txs_pkg::TIMING_RST;
         data_q   <= 8'h00;
         rate_q   <= txs_pkg::RATE_RST;
         level_q  <= txs_pkg::LEVEL_RST;
         cap_q    <= txs_pkg::CAP_RST;
         trim_q   <= txs_pkg::TRIM_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= wb;
         if (wr_tim)  timing_q <= wb;
         if (wr_data) data_q <= wb;
         if (wr_rl)   rate_q[7:0] <= wb;
         if (wr_rh)   rate_q[14:8] <= wb[6:0];
         if (wr_lvl)  level_q <= wb;
         if (wr_chi)  cap_q[8] <= wb[0];
         if (wr_clo)  cap_q[7:0] <= wb;
         if (wr_trim) trim_q <= {3'h0, wb[4:0]}; // Only bits 4:0 stored; bits 7:5 read zero
      end
   end

   // Empty flag and registered notify pulse; a write beats a same-cycle take
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         empty_q  <= 1'b1;
         notify_q <= 1'b0;
      end else begin
         notify_q <= wr_data;
         if (wr_data) begin
            empty_q <= 1'b0;
         end else if (take || !ctrl_q[txs_pkg::CTRL_EN]) begin
            empty_q <= 1'b1;
         end
      end
   end

   // Configuration bundle for the core
   assign cfg.enable                  = ctrl_q[txs_pkg::CTRL_EN];
   assign cfg.force_amplifier_on      = ctrl_q[txs_pkg::CTRL_FPA];
   assign cfg.force_divider_on        = ctrl_q[txs_pkg::CTRL_FDIV];
   assign cfg.force_oscillator_on     = ctrl_q[txs_pkg::CTRL_FLC];
   assign cfg.modulation_select       = ctrl_q[txs_pkg::CTRL_MODE];
   assign cfg.force_deviation         = ctrl_q[txs_pkg::CTRL_FDEV];
   assign cfg.end_action              = ctrl_q[txs_pkg::CTRL_END_LO +: 2];
   assign cfg.serializer_clock_divide = timing_q[txs_pkg::TIM_DIV_LO +: 3];
   assign cfg.edge_time               = timing_q[txs_pkg::TIM_EDGE_LO +: 2];
   assign cfg.group_width             = (timing_q[txs_pkg::TIM_GRP_LO +: 3] == 3'h0)
                                        ? 3'h1 : timing_q[txs_pkg::TIM_GRP_LO +: 3];
   assign cfg.rate                    = rate_q;
   assign cfg.driver_slice_count      = level_q[txs_pkg::LVL_SLICE_LO +: 5];

   txs_core u_core (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .cfg       (cfg),
      .load      (notify_q),
      .load_data (data_q),
      .take      (take),
      .busy      (busy),
      .rf        (rf)
   );

   // Registered front-end drive; boost flag scales bias by 1.5 in the analog
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {lc_oscillator_on, divider_on, amplifier_on, driver_slice_count} <= '0;
         {slice_bias_level, max_drive_boost, tuning_cap_word, freq_deviation} <= '0;
      end else begin
         lc_oscillator_on   <= rf.osc_on;
         divider_on         <= rf.div_on;
         amplifier_on       <= rf.amp_on;
         driver_slice_count <= rf.slices;
         slice_bias_level   <= level_q[2:0];
         max_drive_boost    <= trim_q[txs_pkg::TRIM_BOOST];
         tuning_cap_word    <= cap_q;
         freq_deviation     <= rf.deviation;
      end
   end
endmodule : txs_top

/* txs_pkg.sv */
// Package for the transmit output serializer: register map, fields, reset values, states.
// Assumes a 32-bit AXI4-Lite register bus and the 20 MHz aclk as the serializer base clock.
package txs_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [15:0] IDX_CTRL    = 16'h00A9;
   localparam logic [15:0] IDX_TIMING  = 16'h00AA;
   localparam logic [15:0] IDX_DATA    = 16'h00AB;
   localparam logic [15:0] IDX_RATEL   = 16'h00AC;
   localparam logic [15:0] IDX_RATEH   = 16'h00AD;
   localparam logic [15:0] IDX_LEVEL   = 16'h00CE;
   localparam logic [15:0] IDX_CAP_HI  = 16'h400C;
   localparam logic [15:0] IDX_CAP_LO  = 16'h400D;
   localparam logic [15:0] IDX_TRIM    = 16'h4012;
   localparam logic [15:0] IDX_STATUS  = 16'h4100;
   // Reset values
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [7:0]  TIMING_RST  = 8'h00;
   localparam logic [7:0]  LEVEL_RST   = 8'h00;
   localparam logic [8:0]  CAP_RST     = 9'h000;
   localparam logic [7:0]  TRIM_RST    = 8'h00;
   localparam logic [14:0] RATE_RST    = 15'h0000;
   // Field positions
   localparam int CTRL_EN      = 0;
   localparam int CTRL_FPA     = 1;
   localparam int CTRL_FDIV    = 2;
   localparam int CTRL_FLC     = 3;
   localparam int CTRL_MODE    = 4;
   localparam int CTRL_FDEV    = 5;
   localparam int CTRL_END_LO  = 6;
   localparam int LVL_SLICE_LO = 3;
   localparam int TRIM_BOOST   = 4;
   localparam int TIM_DIV_LO   = 0;
   localparam int TIM_EDGE_LO  = 3;
   localparam int TIM_GRP_LO   = 5;
   // Fixed figures
   localparam logic [6:0]  DEV_FULL    = 7'h7F;
   localparam int          EDGE_BASE   = 8;
   localparam int          SEQ_STEPS   = 4;
   // End-of-data actions
   localparam logic [1:0]  END_OFF  = 2'b00;
   localparam logic [1:0]  END_REP  = 2'b01;
   localparam logic [1:0]  END_ZERO = 2'b10;
   localparam logic [1:0]  END_ONE  = 2'b11;

   // Power sequencer states, Gray along off→osc→div→run
   typedef enum logic [1:0] {
      TXS_OFF = 2'b00,
      TXS_OSC = 2'b01,
      TXS_DIV = 2'b11,
      TXS_RUN = 2'b10
   } txs_pwr_e;

   // Control fields decoded for the serializer core
   typedef struct packed {
      logic        enable;
      logic        force_amplifier_on;
      logic        force_divider_on;
      logic        force_oscillator_on;
      logic        modulation_select;
      logic        force_deviation;
      logic [1:0]  end_action;
      logic [2:0]  serializer_clock_divide;
      logic [1:0]  edge_time;
      logic [2:0]  group_width;
      logic [14:0] rate;
      logic [4:0]  driver_slice_count;
   } txs_cfg_s;

   // Drive towards the analog front end
   typedef struct packed {
      logic       osc_on;
      logic       div_on;
      logic       amp_on;
      logic [4:0] slices;
      logic [6:0] deviation;
   } txs_rf_s;
endpackage : txs_pkg

/* txs_core.sv */
// Serializer core: clock divider, rate timer, symbol shifter, edge ramp, power sequencer.
// Assumes configuration is stable from the register file on the same clock.
`timescale 1ns/1ps
module txs_core (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire txs_pkg::txs_cfg_s cfg,
   input  wire logic              load,
   input  wire logic [7:0]        load_data,
   output logic                   take,
   output logic                   busy,
   output txs_pkg::txs_rf_s       rf
);
   txs_pkg::txs_pwr_e pwr_q;
   logic [2:0]  ck_cnt_q;
   logic [14:0] rate_cnt_q;
   logic [1:0]  edge_div_q;
   logic [2:0]  edge_sub_q;
   logic [7:0]  shift_q;
   logic [7:0]  last_q;
   logic [2:0]  bit_q;
   logic        have_q;
   logic        sym_q;
   logic        dry_q;
   logic        armed_q;
   logic [4:0]  ramp_q;
   logic [1:0]  seq_q;

   // Serializer clock enable: divide by field plus one
   wire ck_en    = (ck_cnt_q == cfg.serializer_clock_divide);
   // Symbol tick every rate serializer clocks
   wire sym_tick = ck_en && (rate_cnt_q + 15'h0001 >= cfg.rate);
   wire edge_en  = ck_en && (edge_sub_q == 3'(txs_pkg::EDGE_BASE - 1))
                   && (edge_div_q == cfg.edge_time);
   wire last_bit = (bit_q == cfg.group_width);
   wire running  = (pwr_q == txs_pkg::TXS_RUN);
   wire seq_tick = ck_en && (seq_q == 2'(txs_pkg::SEQ_STEPS - 1));
   wire stop     = dry_q && (cfg.end_action == txs_pkg::END_OFF);
   // Data-driven symbol, or fill value once data has run out
   wire fill_sym = (cfg.end_action == txs_pkg::END_ONE);
   wire cur_sym  = (dry_q && cfg.end_action != txs_pkg::END_REP) ? fill_sym : sym_q;
   wire amp_key  = running && (cfg.modulation_select || cur_sym) && !stop;
   wire [4:0] ramp_tgt = amp_key ? cfg.driver_slice_count : 5'h00;

   // Dividers and timers
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg.enable) begin
         ck_cnt_q   <= 3'h0;
         rate_cnt_q <= 15'h0000;
         edge_div_q <= 2'h0;
         edge_sub_q <= 3'h0;
         seq_q      <= 2'h0;
      end else if (ck_en) begin
         ck_cnt_q   <= 3'h0;
         rate_cnt_q <= (sym_tick || !running) ? 15'h0000 : rate_cnt_q + 15'h0001;
         edge_sub_q <= edge_sub_q + 3'h1;
         if (edge_sub_q == 3'(txs_pkg::EDGE_BASE - 1)) begin
            edge_div_q <= (edge_div_q == cfg.edge_time) ? 2'h0 : edge_div_q + 2'h1;
         end
         seq_q      <= seq_q + 2'h1;
      end else begin
         ck_cnt_q   <= ck_cnt_q + 3'h1;
      end
   end

   // Power sequencing: oscillator, divider, amplifier up; reverse down
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_q <= txs_pkg::TXS_OFF;
      end else if (!cfg.enable || stop) begin
         if (pwr_q == txs_pkg::TXS_RUN && ramp_q == 5'h00) begin
            pwr_q <= txs_pkg::TXS_DIV;
         end else if (pwr_q == txs_pkg::TXS_DIV) begin
            pwr_q <= txs_pkg::TXS_OSC;
         end else if (pwr_q == txs_pkg::TXS_OSC) begin
            pwr_q <= txs_pkg::TXS_OFF;
         end
      end else if (seq_tick) begin
         case (pwr_q)
            txs_pkg::TXS_OFF: if (armed_q) pwr_q <= txs_pkg::TXS_OSC;
            txs_pkg::TXS_OSC: pwr_q <= txs_pkg::TXS_DIV;
            txs_pkg::TXS_DIV: pwr_q <= txs_pkg::TXS_RUN;
            default:          pwr_q <= pwr_q;
         endcase
      end
   end

   // Shifter: groups sent LSB first, next byte taken back to back
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg.enable) begin
         shift_q <= 8'h00;
         last_q  <= 8'h00;
         bit_q   <= 3'h0;
         have_q  <= 1'b0;
         armed_q <= 1'b0;
         sym_q   <= 1'b0;
         dry_q   <= 1'b0;
         take    <= 1'b0;
      end else begin
         take <= 1'b0;
         if (load) begin
            have_q <= 1'b1;
         end
         if (!armed_q && have_q) begin // First byte is consumed, so it is sent once
            sym_q   <= load_data[0];
            shift_q <= load_data;
            last_q  <= load_data;
            have_q  <= load;
            armed_q <= 1'b1;
            take    <= 1'b1;
         end else if (running && sym_tick) begin
            if (!last_bit) begin
               bit_q <= bit_q + 3'h1;
               sym_q <= shift_q[bit_q + 3'h1];
            end else begin
               bit_q <= 3'h0;
               if (have_q) begin
                  shift_q <= load_data;
                  last_q  <= load_data;
                  sym_q   <= load_data[0];
                  dry_q   <= 1'b0;
                  have_q  <= load;
                  take    <= 1'b1;
               end else begin
                  shift_q <= last_q; // Repeat group on underrun
                  sym_q   <= last_q[0];
                  dry_q   <= 1'b1;
               end
            end
         end
      end
   end

   // Edge ramp of slice count, bypassed by the force bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramp_q <= 5'h00;
      end else if (cfg.force_amplifier_on) begin
         ramp_q <= cfg.driver_slice_count;
      end else if (edge_en || !cfg.enable) begin
         if (!cfg.enable) begin
            ramp_q <= 5'h00;
         end else if (ramp_q < ramp_tgt) begin
            ramp_q <= ramp_q + 5'h01;
         end else if (ramp_q > ramp_tgt) begin
            ramp_q <= ramp_q - 5'h01;
         end
      end
   end

   // Front-end outputs, forces override scheduling
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rf   <= '0;
         busy <= 1'b0;
      end else begin
         rf.osc_on    <= cfg.force_oscillator_on || (pwr_q != txs_pkg::TXS_OFF);
         rf.div_on    <= cfg.force_divider_on
                         || pwr_q == txs_pkg::TXS_DIV || pwr_q == txs_pkg::TXS_RUN;
         rf.amp_on    <= cfg.force_amplifier_on || running;
         rf.slices    <= ramp_q;
         rf.deviation <= (cfg.force_deviation
                          || (cfg.modulation_select && running && cur_sym))
                         ? txs_pkg::DEV_FULL : 7'h00;
         busy         <= (pwr_q != txs_pkg::TXS_OFF);
      end
   end
endmodule : txs_core

/* txs_properties.sv */
// Checker for txs_top: bus handshakes, deviation levels, front-end power order.
// Assumes it is bound to txs_top and sees its ports only; one clock domain.
`timescale 1ns/1ps
module txs_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        lc_oscillator_on,
   input wire logic        divider_on,
   input wire logic        amplifier_on,
   input wire logic [6:0]  freq_deviation
);
   // Every check runs on aclk and sleeps through reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Register bus handshakes
   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   AST_B_SOON: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |-> ##[1:4] s_axi_bvalid) else $error("no write response");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid repeated");
   AST_AR_TO_R: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("rvalid late");
   AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid repeated");
   AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
      else $error("upper read bits set");
   // Deviation bus and power order
   AST_DEV_LEVEL: assert property (freq_deviation == 7'h0 || freq_deviation == 7'h7f)
      else $error("bad deviation level");
   AST_DIV_OSC: assert property ($rose(divider_on) |-> lc_oscillator_on)
      else $error("divider before oscillator");
   AST_AMP_DIV: assert property ($rose(amplifier_on) |-> divider_on)
      else $error("amplifier before divider");
   AST_OSC_LAST: assert property ($fell(lc_oscillator_on) |-> !divider_on)
      else $error("oscillator off before divider");
   // Main scenarios reached
   cover property ($rose(amplifier_on));
   cover property ($fell(lc_oscillator_on));
   cover property (freq_deviation == 7'h7f);
endmodule : txs_properties

bind txs_top txs_properties u_props (.*);

/* txs_rf_model.sv */
// Front-end model: records power order, slice steps and deviation edge spacing.
// Assumes one clock; rf_rst_n clears the records before a burst.
`timescale 1ns/1ps
module txs_rf_model (
   input wire logic        aclk,
   input wire logic        rf_rst_n,
   input wire logic        osc_on,
   input wire logic        div_on,
   input wire logic        amp_on,
   input wire logic [4:0]  slices,
   input wire logic [6:0]  deviation,
   output logic [15:0]     n_edges,
   output logic [15:0]     gap_min,
   output logic [15:0]     gap_max,
   output logic            order_bad,
   output logic            ramp_bad
);
   logic [15:0] gap_q;
   logic [6:0]  dev_q;
   logic [4:0]  sl_q;
   logic        osc_q, div_q, amp_q, misorder, big_step;
   // Out-of-order power change and slice jumps over one step
   assign misorder = (div_on && !div_q && !osc_on) || (amp_on && !amp_q && !div_on)
      || (!osc_on && osc_q && div_on) || (!div_on && div_q && amp_on);
   assign big_step = 6'(slices) > 6'(sl_q) + 6'd1 || 6'(sl_q) > 6'(slices) + 6'd1;
   // Previous values
   always_ff @(posedge aclk) {dev_q, sl_q, osc_q, div_q, amp_q} <= {deviation, slices,
      osc_on, div_on, amp_on};
   // Records of the burst
   always_ff @(posedge aclk) begin
      if (!rf_rst_n) begin
         {gap_q, n_edges, gap_max, order_bad, ramp_bad} <= '0;
         gap_min <= 16'hffff;
      end else begin
         gap_q <= gap_q + 16'd1;
         order_bad <= order_bad | misorder;
         ramp_bad <= ramp_bad | big_step;
         if (deviation != dev_q) begin
            n_edges <= n_edges + 16'd1;
            gap_q <= 16'd1;
            if (n_edges != 16'd0 && gap_q < gap_min) gap_min <= gap_q;
            if (n_edges != 16'd0 && gap_q > gap_max) gap_max <= gap_q;
         end
      end
   end
endmodule : txs_rf_model

/* tx_output_serializer_test.sv */
// Bench for txs_top: register access, forced front end, one FSK burst.
// Assumes txs_rf_model watches the front end and the checker is bound to txs_top.
`timescale 1ns/1ps
module tx_output_serializer_test;
   logic        aclk, aresetn, rf_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, lc_oscillator_on, divider_on, amplifier_on;
   logic        max_drive_boost, order_bad, ramp_bad;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  s_axi_awprot, s_axi_arprot, slice_bias_level;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
   logic [4:0]  driver_slice_count;
   logic [8:0]  tuning_cap_word;
   logic [6:0]  freq_deviation;
   logic [15:0] n_edges, gap_min, gap_max;
   int          n_errors = 0;
   int          samples_checked = 0;
   txs_top uut (.*);
   txs_rf_model u_rf (.aclk(aclk), .rf_rst_n(rf_rst_n), .osc_on(lc_oscillator_on),
      .div_on(divider_on), .amp_on(amplifier_on), .slices(driver_slice_count),
      .deviation(freq_deviation), .n_edges(n_edges), .gap_min(gap_min), .gap_max(gap_max),
      .order_bad(order_bad), .ramp_bad(ramp_bad));
   // Clock and watchdog
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      #(30000 * 50);
      n_errors++;
      $display("ERROR %0t: watchdog", $time);
      end_of_test();
   end
   // Comparison and bus tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {i, 2'b00, 24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'h0);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] i);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 2'b00, 2'b11};
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [15:0] i, input logic [31:0] e, input logic [31:0] m);
      rd(i);
      chk(rdat & m, e);
   endtask : rc
   // Forced front end, level fields, forced deviation
   task automatic t_force;
      wr(txs_pkg::IDX_LEVEL, 8'hab);
      wr(txs_pkg::IDX_CTRL, 8'h0e);
      repeat (3) @(posedge aclk);
      chk(32'(driver_slice_count), 32'h15);
      chk(32'(slice_bias_level), 32'h3);
      chk(32'({lc_oscillator_on, divider_on, amplifier_on}), 32'h7);
      rc(txs_pkg::IDX_LEVEL, 32'hab, 32'hffff_ffff);
      wr(txs_pkg::IDX_CTRL, 8'h20);
      repeat (3) @(posedge aclk);
      chk(32'(freq_deviation), 32'h7f);
      wr(txs_pkg::IDX_CTRL, 8'h00);
   endtask : t_force
   // Tuning word, boost bit by read-modify-write, unmapped read
   task automatic t_regs;
      wr(txs_pkg::IDX_CAP_HI, 8'hff);
      wr(txs_pkg::IDX_CAP_LO, 8'h34);
      repeat (2) @(posedge aclk);
      chk(32'(tuning_cap_word), 32'h134);
      rc(txs_pkg::IDX_CAP_HI, 32'h1, 32'hffff_ffff);
      rd(txs_pkg::IDX_TRIM);
      wr(txs_pkg::IDX_TRIM, rdat[7:0] | 8'h10);
      repeat (2) @(posedge aclk);
      chk(32'(max_drive_boost), 32'h1);
      rd(16'h0001);
      chk({rdat[29:0], rrsp}, 32'h2);
   endtask : t_regs
   // Disabled write, then one FSK group of alternating symbols to power-down
   task automatic t_stream;
      rf_rst_n <= 1'b0;
      wr(txs_pkg::IDX_TIMING, 8'he1);
      wr(txs_pkg::IDX_RATEL, 8'h06);
      wr(txs_pkg::IDX_LEVEL, 8'hf8);
      wr(txs_pkg::IDX_CTRL, 8'h10);
      wr(txs_pkg::IDX_DATA, 8'h55);
      repeat (100) @(posedge aclk);
      chk(32'(lc_oscillator_on), 32'h0);
      rf_rst_n <= 1'b1;
      wr(txs_pkg::IDX_CTRL, 8'h11);
      wr(txs_pkg::IDX_DATA, 8'h55);
      for (int i = 0; i < 2000 && !amplifier_on; i++) @(posedge aclk);
      for (int i = 0; i < 5000 && lc_oscillator_on; i++) @(posedge aclk);
      chk(32'(lc_oscillator_on), 32'h0);
      chk(32'(order_bad), 32'h0);
      chk(32'(ramp_bad), 32'h0);
      chk(32'(n_edges), 32'h8);
      chk({gap_min, gap_max}, {16'd12, 16'd12});
   endtask : t_stream
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      {aresetn, rf_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_awprot, s_axi_arprot} = {4'hf, 6'h0};
      repeat (4) @(posedge aclk);
      {aresetn, rf_rst_n} <= 2'b11;
      rc(txs_pkg::IDX_CTRL, 32'h0, 32'hffff_ffff);
      rc(txs_pkg::IDX_STATUS, 32'h1, 32'h1);
      t_force();
      t_regs();
      t_stream();
      end_of_test();
   end
endmodule : tx_output_serializer_test
